// [bench/acd_assertions.sv]
// Port checker for the clock configuration block.
// Assumes it is bound to acd_clock_config; all on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module acd_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       src_tick,
  input wire logic       mclk_tick,
  input wire logic       master_mode,
  input wire logic       irq_event,
  input wire logic       osr_clk_tick,
  input wire logic       ofs_clk_tick,
  input wire logic       bitclk_tick,
  input wire logic       frameclk_tick,
  input wire logic       interp_16x_active,
  input wire logic       irq_pin_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence flag_rd;
    reg_rd && reg_addr == 8'h23;
  endsequence
  sequence mode_wr;
    reg_wr && reg_addr == 8'h22 ##1 !(reg_wr && reg_addr == 8'h22);
  endsequence

  chk_irq_set: assert property (irq_event |=> irq_pin_out)
    else $error("pin not set by event");
  chk_irq_hold: assert property (irq_pin_out && !reg_rd |=> irq_pin_out)
    else $error("pin dropped without read");
  chk_irq_cause: assert property ($rose(irq_pin_out) |-> $past(irq_event))
    else $error("pin rose without event");
  chk_irq_clear: assert property (reg_rd && reg_addr == 8'h23 && !irq_event |=> !irq_pin_out)
    else $error("pin not cleared by read");
  chk_flag_data: assert property (flag_rd |=> reg_rdata[0] == $past(irq_pin_out))
    else $error("flag read wrong");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_src_cause: assert property (osr_clk_tick || ofs_clk_tick |-> $past(src_tick))
    else $error("source divider pulse without tick");
  chk_bit_slave: assert property (!master_mode |=> !bitclk_tick)
    else $error("bit clock while slave");
  chk_bit_cause: assert property (bitclk_tick |-> $past(mclk_tick) && $past(master_mode))
    else $error("bit clock without mclk");
  chk_frame_cause: assert property (frameclk_tick |-> $past(bitclk_tick))
    else $error("frame pulse without bit clock");
  chk_interp_upd: assert property (mode_wr |=> interp_16x_active == $past(reg_wdata[4], 2))
    else $error("interpolation select not applied");
endmodule : acd_chk

bind acd_clock_config acd_chk u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .src_tick, .mclk_tick, .master_mode, .irq_event, .osr_clk_tick,
  .ofs_clk_tick, .bitclk_tick, .frameclk_tick, .interp_16x_active, .irq_pin_out);

`default_nettype wire

// [bench/acd_tick_src.sv]
// Partner model: a clock source seen as a stream of one-cycle enables.
// Assumes sys_clk and rst_b of the block; gap is held steady while measured.
`timescale 1ns/1ps
`default_nettype none

module acd_tick_src (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] gap,
  output logic            tick
);
  logic [1:0] cnt;

  // One tick every gap+1 cycles, so periods scale with the gap
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt  <= 2'h0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == gap);
      cnt  <= (cnt >= gap) ? 2'h0 : cnt + 2'h1;
    end
  end
endmodule : acd_tick_src

`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for the clock configuration block.
// Assumes the package, defs header and checker bind are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "acd_defs.svh"

module tb_top;
  import acd_pkg::*;
  logic        sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        master_mode = 1'b1, irq_event = 1'b0, src_tick, mclk_tick;
  logic [6:0]  auto_osr_div = 7'h09;
  logic [2:0]  auto_speed_mode = 3'h3;
  logic [1:0]  gs = 2'h0, gm = 2'h0;
  logic        osr_clk_tick, ofs_clk_tick, bitclk_tick, frameclk_tick;
  logic        interp_16x_active, rate_valid, auto_mode_active, irq_pin_out, rd_seen = 1'b0;
  acd_rate_t   rate_sel;
  logic [15:0] exp_q[$];
  logic [31:0] dv;
  logic [7:0]  d, f23, e;
  int          seed, failures = 0, samples_checked = 0, cycles = 0, i, n;
  logic [7:0]  rst_tab [8] = '{8'h01, 8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h03, 8'h00};
  // Long frame ratio meets the fastest bit clock, so stale frame periods stay short
  logic [31:0] dtab [4] = '{32'h8000_00FF, 32'h0506_0203, 32'h0000_0001, 32'h7FFF_7F00};

  acd_clock_config dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .src_tick, .mclk_tick, .master_mode, .auto_osr_div, .auto_speed_mode,
    .irq_event, .osr_clk_tick, .ofs_clk_tick, .bitclk_tick, .frameclk_tick,
    .interp_16x_active, .rate_sel, .rate_valid, .auto_mode_active, .irq_pin_out);
  acd_tick_src u_src (.sys_clk, .rst_b, .gap(gs), .tick(src_tick));
  acd_tick_src u_mck (.sys_clk, .rst_b, .gap(gm), .tick(mclk_tick));

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back({8'h00, v});
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  function automatic logic pulse_of(input int k);
    case (k)
      0: return osr_clk_tick;
      1: return ofs_clk_tick;
      2: return bitclk_tick;
      default: return frameclk_tick;
    endcase
  endfunction : pulse_of

  // Third interval only, so the new ratio has surely been loaded
  task automatic per(input int k, input int ex);
    int c;
    for (int p = 0; p < 3; p++) begin
      c = 0;
      do begin
        @(posedge sys_clk);
        c++;
      end while (pulse_of(k) !== 1'b1 && c < 8000);
    end
    check("period", 16'(c), 16'(ex));
  endtask : per

  function automatic logic [7:0] stat(input logic [2:0] c, input logic h, input logic au);
    logic [1:0] ix;
    ix = (c == 3'h3) ? 2'h0 : (c == 3'h4) ? 2'h1 : (c == 3'h7) ? 2'h2 : 2'h3;
    return {2'h0, ix, 1'b0, h, au, ix != 2'h3};
  endfunction : stat

  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    if (rd_seen) check("reg_rdata", {8'h00, reg_rdata}, exp_q.pop_front());
    rd_seen <= reg_rd;
    cycles++;
    if (cycles == 90000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    seed = 93;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) rd(8'h1E + 8'(i), rst_tab[i]);
    rd(8'h26, 8'h00);
    $display("Test reset values done");
    for (i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      wr(8'h1E + 8'(i), d);
      rd(8'h1E + 8'(i), d);
    end
    f23 = 8'($random(seed));
    wr(8'h23, f23);
    rd(8'h23, {f23[7:1], 1'b0});
    wr(8'h26, f23);
    rd(8'h26, 8'h00);
    wr(8'h24, f23);
    rd(8'h24, stat(3'h3, d[4], 1'b1));
    $display("Test register access done");
    wr(8'h25, 8'h02);
    for (i = 0; i < 8; i++) begin
      d = {3'h0, 1'($random(seed)), 1'b0, 3'(i)};
      wr(8'h22, d);
      e = stat(3'(i), d[4], 1'b0);
      rd(8'h24, e);
      check("mode_ports", {11'h000, rate_sel, interp_16x_active, auto_mode_active, rate_valid}, {11'h000, e[5:4], e[2:0]});
    end
    wr(8'h25, 8'h00);
    rd(8'h24, stat(auto_speed_mode, d[4], 1'b1));
    $display("Test speed modes done");
    wr(8'h25, 8'h02);
    gs <= 2'($random(seed));
    gm <= 2'($random(seed));
    for (i = 0; i < 4; i++) begin
      dv = dtab[i];
      d = 8'($random(seed)) & 8'h7F;
      if (i == 2) dv[31:8] = {d, d, d};
      wr(8'h1E, dv[31:24]);
      wr(8'h1F, dv[23:16]);
      wr(8'h20, dv[15:8]);
      wr(8'h21, dv[7:0]);
      per(0, (dv[30:24] + 1) * (gs + 1));
      per(1, (dv[22:16] + 1) * (gs + 1));
      per(2, (dv[14:8] + 1) * (gm + 1));
      per(3, (dv[7:0] + 1) * (dv[14:8] + 1) * (gm + 1));
    end
    wr(8'h25, 8'h00);
    per(0, (auto_osr_div + 1) * (gs + 1));
    master_mode <= 1'b0;
    n = 0;
    // A pulse launched at the switching edge is still legal
    @(posedge sys_clk);
    repeat (200) @(posedge sys_clk) n += int'(bitclk_tick) + int'(frameclk_tick);
    check("slave_bitclk", 16'(n), 16'h0000);
    $display("Test dividers done");
    @(posedge sys_clk) irq_event <= 1'b1;
    @(posedge sys_clk) irq_event <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("irq_pin", {15'h0, irq_pin_out}, 16'h0001);
    rd(8'h23, {f23[7:1], 1'b1});
    @(posedge sys_clk);
    check("irq_pin", {15'h0, irq_pin_out}, 16'h0000);
    rd(8'h23, {f23[7:1], 1'b0});
    irq_event <= 1'b1;
    rd(8'h23, {f23[7:1], 1'b1});
    irq_event <= 1'b0;
    @(posedge sys_clk);
    check("irq_pin", {15'h0, irq_pin_out}, 16'h0001);
    rd(8'h23, {f23[7:1], 1'b1});
    rd(8'h23, {f23[7:1], 1'b0});
    $display("Test interrupt flag done");
    repeat (3) @(posedge sys_clk);
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire

// [verilog/acd_clock_config.sv]
// Clock configuration core: divider registers, interpolation and speed mode,
// master bit and frame clock generation, sticky pin-interrupt flag.
// Assumes source and MCLK arrive as one-cycle enables synchronous to sys_clk,
// and the auto-set divider and speed choices come from neighbouring logic.
//
// Function
// - Oversampling clock is source clock divided by seven-bit setting plus one.
// - In auto mode the manual oversampling divider is ignored; internal choice used.
// - Offset calibrator clock is source divided by seven-bit setting plus one.
// - As master, bit clock is MCLK divided by seven-bit setting plus one.
// - As master, frame clock is bit clock divided by eight-bit setting plus one.
// - Interpolation runs 8x when select bit clear, 16x when set.
// - Speed code 011 is 48 kHz, 100 is 88.2-96 kHz, 111 is 32 kHz.
// - Read-only sticky flag captures interrupt pin assertion.
// - Reading the flag register clears flag and interrupt pin.
// - One bit selects auto clock setup when clear, manual fields when set.
`timescale 1ns/1ps
`default_nettype none
`include "acd_defs.svh"

module acd_clock_config (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // Register port
  input  wire logic [`ACD_ADDR_W-1:0]     reg_addr,
  input  wire logic [`ACD_DATA_W-1:0]     reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [`ACD_DATA_W-1:0]     reg_rdata,
  // Clock enables and mode inputs
  input  wire logic                       src_tick,
  input  wire logic                       mclk_tick,
  input  wire logic                       master_mode,
  input  wire logic [6:0]                 auto_osr_div,
  input  wire logic [2:0]                 auto_speed_mode,
  input  wire logic                       irq_event,
  // Derived enables and mode outputs
  output logic                            osr_clk_tick,
  output logic                            ofs_clk_tick,
  output logic                            bitclk_tick,
  output logic                            frameclk_tick,
  output logic                            interp_16x_active,
  output acd_pkg::acd_rate_t              rate_sel,
  output logic                            rate_valid,
  output logic                            auto_mode_active,
  output logic                            irq_pin_out
);

  import acd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] oversample_clock_divider;
  logic [7:0] offset_calibrator_clock_divider;
  logic [7:0] master_bitclock_divider;
  logic [7:0] master_frameclock_divider;
  logic [7:0] interpolation_and_rate_mode;
  logic [7:0] interrupt_sticky_flag;
  logic [7:0] clock_autoset_control;

  logic       wr_osr;
  logic       wr_ofs;
  logic       wr_bck;
  logic       wr_frm;
  logic       wr_mode;
  logic       wr_flag;
  logic       wr_auto;
  logic       rd_flag;

  logic       pin_irq_sticky_flag;
  logic [6:0] oversample_div_value;
  logic [6:0] offset_cal_div_value;
  logic [6:0] master_bitclk_div_value;
  logic [7:0] master_frameclk_div_value;
  logic       interp_16x_select;
  logic [2:0] sample_rate_speed_mode;
  logic       auto_clock_config_disable;

  logic       auto_on;
  logic [6:0] next_osr_div;
  logic [2:0] next_speed;
  acd_rate_t  next_rate;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic acd_rate_t rate_decode(input logic [2:0] code);
    unique case (code)
      `ACD_SPEED_48K: rate_decode = ACD_RATE_48K;
      `ACD_SPEED_96K: rate_decode = ACD_RATE_96K;
      `ACD_SPEED_32K: rate_decode = ACD_RATE_32K;
      default:        rate_decode = ACD_RATE_RSVD;
    endcase
  endfunction : rate_decode

  function automatic logic [7:0] widen7(input logic [6:0] v);
    widen7 = {1'b0, v};
  endfunction : widen7

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign wr_osr  = reg_wr && hit(reg_addr, `ACD_OFF_OSR_DIV);
  assign wr_ofs  = reg_wr && hit(reg_addr, `ACD_OFF_OFS_DIV);
  assign wr_bck  = reg_wr && hit(reg_addr, `ACD_OFF_BCK_DIV);
  assign wr_frm  = reg_wr && hit(reg_addr, `ACD_OFF_FRM_DIV);
  assign wr_mode = reg_wr && hit(reg_addr, `ACD_OFF_MODE);
  assign wr_flag = reg_wr && hit(reg_addr, `ACD_OFF_IRQ_FLAG);
  assign wr_auto = reg_wr && hit(reg_addr, `ACD_OFF_AUTO_CTL);
  assign rd_flag = reg_rd && hit(reg_addr, `ACD_OFF_IRQ_FLAG);

  ////////////////////////////////////////////////////////////////////////////
  // Divider registers
  // Reserved top bits are kept as written and read back.

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      oversample_clock_divider <= `ACD_RST_OSR_DIV;
    end else if (wr_osr) begin
      oversample_clock_divider <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_calibrator_clock_divider <= `ACD_RST_OFS_DIV;
    end else if (wr_ofs) begin
      offset_calibrator_clock_divider <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_bitclock_divider <= `ACD_RST_BCK_DIV;
    end else if (wr_bck) begin
      master_bitclock_divider <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_frameclock_divider <= `ACD_RST_FRM_DIV;
    end else if (wr_frm) begin
      master_frameclock_divider <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      interpolation_and_rate_mode <= `ACD_RST_MODE;
    end else if (wr_mode) begin
      interpolation_and_rate_mode <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_autoset_control <= `ACD_RST_AUTO_CTL;
    end else if (wr_auto) begin
      clock_autoset_control <= reg_wdata;
    end
  end

  assign oversample_div_value      = oversample_clock_divider[`ACD_SEVEN_MSB:0];
  assign offset_cal_div_value      = offset_calibrator_clock_divider[`ACD_SEVEN_MSB:0];
  assign master_bitclk_div_value   = master_bitclock_divider[`ACD_SEVEN_MSB:0];
  assign master_frameclk_div_value = master_frameclock_divider;
  assign interp_16x_select         = interpolation_and_rate_mode[`ACD_INTERP_BIT];
  assign sample_rate_speed_mode    =
    interpolation_and_rate_mode[`ACD_SPEED_MSB:`ACD_SPEED_LSB];
  assign auto_clock_config_disable = clock_autoset_control[`ACD_AUTO_DIS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sticky interrupt flag

  // read clears flag
  // An event in the clearing cycle wins, so no assertion is lost.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_irq_sticky_flag <= 1'b0;
    end else if (irq_event) begin
      pin_irq_sticky_flag <= 1'b1;
    end else if (rd_flag) begin
      pin_irq_sticky_flag <= 1'b0;
    end
  end

  // Reserved upper bits of the flag register are plain storage.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_sticky_flag <= `ACD_RST_IRQ_FLAG;
    end else if (wr_flag) begin
      interrupt_sticky_flag <= {reg_wdata[7:1], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_pin_out <= 1'b0;
    end else if (irq_event) begin
      irq_pin_out <= 1'b1;
    end else if (rd_flag) begin
      irq_pin_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto or manual selection

  assign auto_on = !auto_clock_config_disable;

  assign next_osr_div = auto_on ? auto_osr_div : oversample_div_value;

  assign next_speed = auto_on ? auto_speed_mode : sample_rate_speed_mode;

  assign next_rate = rate_decode(next_speed);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_sel   <= ACD_RATE_RSVD;
      rate_valid <= 1'b0;
    end else begin
      rate_sel   <= next_rate;
      rate_valid <= (next_rate != ACD_RATE_RSVD);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      interp_16x_active <= 1'b0;
    end else begin
      interp_16x_active <= interp_16x_select;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_mode_active <= 1'b1;
    end else begin
      auto_mode_active <= auto_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers

  acd_div_if osr_if ();
  acd_div_if ofs_if ();
  acd_div_if bck_if ();
  acd_div_if frm_if ();

  assign osr_if.tick  = src_tick;
  assign osr_if.ratio = widen7(next_osr_div);

  assign ofs_if.tick  = src_tick;
  assign ofs_if.ratio = widen7(offset_cal_div_value);

  // master bit clock
  // Idle outside master mode; the count holds and resumes where it stopped.
  assign bck_if.tick  = mclk_tick && master_mode;
  assign bck_if.ratio = widen7(master_bitclk_div_value);

  assign frm_if.tick  = bck_if.pulse && master_mode;
  assign frm_if.ratio = master_frameclk_div_value;

  acd_divider u_osr_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .dv      (osr_if.div)
  );

  acd_divider u_ofs_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .dv      (ofs_if.div)
  );

  acd_divider u_bck_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .dv      (bck_if.div)
  );

  acd_divider u_frm_div (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .dv      (frm_if.div)
  );

  assign osr_clk_tick  = osr_if.pulse;
  assign ofs_clk_tick  = ofs_if.pulse;
  assign bitclk_tick   = bck_if.pulse;
  assign frameclk_tick = frm_if.pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // Registered one cycle after the strobe; unmapped addresses read zero.

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ACD_OFF_OSR_DIV:  reg_rdata <= oversample_clock_divider;
        `ACD_OFF_OFS_DIV:  reg_rdata <= offset_calibrator_clock_divider;
        `ACD_OFF_BCK_DIV:  reg_rdata <= master_bitclock_divider;
        `ACD_OFF_FRM_DIV:  reg_rdata <= master_frameclock_divider;
        `ACD_OFF_MODE:     reg_rdata <= interpolation_and_rate_mode;
        `ACD_OFF_IRQ_FLAG: reg_rdata <= {interrupt_sticky_flag[7:1],
                                         pin_irq_sticky_flag};
        `ACD_OFF_STATUS:   reg_rdata <= {2'h0, rate_sel, 1'b0,
                                         interp_16x_active,
                                         auto_mode_active, rate_valid};
        `ACD_OFF_AUTO_CTL: reg_rdata <= clock_autoset_control;
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : acd_clock_config

`default_nettype wire

// [verilog/acd_defs.svh]
// Offsets, field positions, reset values and widths for the audio clock divider block.
// Assumes inclusion by bare name from every file that decodes the register map.
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH

`define ACD_ADDR_W        8
`define ACD_DATA_W        8
`define ACD_DIV_W         8

`define ACD_OFF_OSR_DIV   8'h1E
`define ACD_OFF_OFS_DIV   8'h1F
`define ACD_OFF_BCK_DIV   8'h20
`define ACD_OFF_FRM_DIV   8'h21
`define ACD_OFF_MODE      8'h22
`define ACD_OFF_IRQ_FLAG  8'h23
`define ACD_OFF_STATUS    8'h24
`define ACD_OFF_AUTO_CTL  8'h25

`define ACD_RST_OSR_DIV   8'h01
`define ACD_RST_OFS_DIV   8'h04
`define ACD_RST_BCK_DIV   8'h00
`define ACD_RST_FRM_DIV   8'h00
`define ACD_RST_MODE      8'h04
`define ACD_RST_IRQ_FLAG  8'h00
`define ACD_RST_AUTO_CTL  8'h00

`define ACD_SEVEN_MSB     6
`define ACD_INTERP_BIT    4
`define ACD_SPEED_MSB     2
`define ACD_SPEED_LSB     0
`define ACD_FLAG_BIT      0
`define ACD_AUTO_DIS_BIT  1

`define ACD_SPEED_48K     3'h3
`define ACD_SPEED_96K     3'h4
`define ACD_SPEED_32K     3'h7

`define ACD_ST_VALID_BIT  0
`define ACD_ST_AUTO_BIT   1
`define ACD_ST_16X_BIT    2
`define ACD_ST_RATE_LSB   4

`endif

// [verilog/acd_div_if.sv]
// Carrier between the control logic and one divider instance.
// Assumes all signals are on sys_clk.
`timescale 1ns/1ps
`default_nettype none

interface acd_div_if;
  logic       tick;
  logic [7:0] ratio;
  logic       pulse;

  modport ctrl (output tick, output ratio, input pulse);
  modport div  (input tick, input ratio, output pulse);
endinterface : acd_div_if

`default_nettype wire

// [verilog/acd_divider.sv]
// Programmable divider of an enable stream; emits one pulse per period.
// Assumes tick is a one-cycle enable on sys_clk; ratio is divide value minus one.
`timescale 1ns/1ps
`default_nettype none

module acd_divider (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  acd_div_if.div    dv
);

  logic [7:0] count;
  logic [7:0] active_ratio;

  ////////////////////////////////////////////////////////////////////////////
  // boundary-only reload
  // A new ratio is taken only when a period ends, so no short pulse appears.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count        <= 8'h00;
      active_ratio <= 8'h00;
    end else if (dv.tick) begin
      if (count >= active_ratio) begin
        count        <= 8'h00;
        active_ratio <= dv.ratio;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dv.pulse <= 1'b0;
    end else begin
      dv.pulse <= dv.tick && (count >= active_ratio);
    end
  end

endmodule : acd_divider

`default_nettype wire

// [verilog/acd_pkg.sv]
// Types shared by the audio clock divider block.
// Assumes nothing beyond a SystemVerilog compiler.
package acd_pkg;

  typedef enum logic [1:0] {
    ACD_RATE_48K,
    ACD_RATE_96K,
    ACD_RATE_32K,
    ACD_RATE_RSVD
  } acd_rate_t;

endpackage : acd_pkg
